// File: rtl/sdmpm_defs.svh
// Strap bit positions, mode codes and timing constants for the strap decoder
`ifndef SDMPM_DEFS_SVH
`define SDMPM_DEFS_SVH

`define SDMPM_STRAP_W        16
`define SDMPM_BIT_DEBOUNCE   0
`define SDMPM_MODE_LSB       1
`define SDMPM_MODE_MSB       3
`define SDMPM_DEVID_LSB      4
`define SDMPM_DEVID_MSB      6
`define SDMPM_BIT_EEPROM_DIS 7
`define SDMPM_BIT_HOTSWAP    9
`define SDMPM_BIT_PWRSAVE    11
`define SDMPM_BIT_TIMEOUT    12
`define SDMPM_CODE_PAR16     3'h0
`define SDMPM_CODE_PAR8      3'h1
`define SDMPM_CODE_SER_MII   3'h2
`define SDMPM_CODE_SER_ONLY  3'h3
`define SDMPM_CODE_UNMANAGED 3'h7
`define SDMPM_CLK_HZ         40000000
`define SDMPM_TIMEOUT_S      5
`define SDMPM_TIMEOUT_CYC    (`SDMPM_TIMEOUT_S * `SDMPM_CLK_HZ)
`define SDMPM_IDLE_CYC       1024

`endif

// File: rtl/sdmpm_pkg.sv
// Types shared by the strap decoder and its per-port power-saving state machine
`default_nettype none
package sdmpm_pkg;

  typedef enum logic [2:0] {
    SDMPM_IF_PAR16   = 3'h0,
    SDMPM_IF_PAR8    = 3'h1,
    SDMPM_IF_SER_MII = 3'h3,
    SDMPM_IF_SER     = 3'h2,
    SDMPM_IF_UNMAN   = 3'h6,
    SDMPM_IF_RSVD    = 3'h7
  } sdmpm_if_t;

  typedef enum logic [1:0] {
    SDMPM_PS_IDLE  = 2'h0,
    SDMPM_PS_AWAKE = 2'h1,
    SDMPM_PS_SLEEP = 2'h3
  } sdmpm_ps_t;

endpackage : sdmpm_pkg
`default_nettype wire

// File: rtl/sdmpm_port_ps.sv
// Per-port inactivity detector and power-saving state machine
`default_nettype none
`include "sdmpm_defs.svh"
module sdmpm_port_ps #(
  parameter int unsigned IDLE_CYC = `SDMPM_IDLE_CYC
) (
  input  wire logic clk_i,     // System clock
  input  wire logic sys_rst_i, // Synchronous reset, active high
  input  wire logic ce_i,      // Clock enable
  input  wire logic enable_i,  // Power saving enabled
  input  wire logic active_i,  // Port activity seen this cycle
  output logic      sleep_o    // MAC in reduced-power state
);

  typedef struct packed {
    sdmpm_pkg::sdmpm_ps_t st;
    logic [31:0]          cnt;
  } sdmpm_ps_state_t;

  sdmpm_ps_state_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      sdmpm_pkg::SDMPM_PS_IDLE:
      begin
        s_d.cnt = 32'h0;
        if (enable_i)
          s_d.st = sdmpm_pkg::SDMPM_PS_AWAKE;
      end
      sdmpm_pkg::SDMPM_PS_AWAKE:
      begin
        if (!enable_i || active_i)
          s_d.cnt = 32'h0;
        else
          s_d.cnt = s_q.cnt + 32'h1;
        // RL11 enter sleep
        if (enable_i && !active_i && s_q.cnt >= IDLE_CYC - 1)
          s_d.st = sdmpm_pkg::SDMPM_PS_SLEEP;
      end
      sdmpm_pkg::SDMPM_PS_SLEEP:
      begin
        s_d.cnt = 32'h0;
        // RL12 wake on activity
        if (active_i || !enable_i)
          s_d.st = sdmpm_pkg::SDMPM_PS_AWAKE;
      end
      default:
        s_d.st = sdmpm_pkg::SDMPM_PS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  assign sleep_o = (s_q.st == sdmpm_pkg::SDMPM_PS_SLEEP);

  property p_wake;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sleep_o && active_i && ce_i) |=> !sleep_o;
  endproperty
  a_wake: assert property (p_wake) else $error("port did not wake"); // RL12

  property p_sleep_needs_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($rose(sleep_o)) |-> $past(enable_i) && !$past(active_i);
  endproperty
  a_sleep_needs_idle: assert property (p_sleep_needs_idle) // RL11
    else $error("sleep entered without idle");

endmodule : sdmpm_port_ps
`default_nettype wire

// File: rtl/sdmpm_strap_decode.sv
// Strap capture, management mode decode and management pin remapping
//
// What this block does
// RL1 - Strap bits 3:1 pick 16-bit, 8-bit, serial+MII or serial-only mode.
// RL2 - Serial-only mode leaves data pins and address pin 2 undriven.
// RL3 - Code 111 alone turns address 0 into SDA, address 1 into SCL.
// RL4 - Serial modes: write-enable clocks, read-enable sends, select receives.
// RL5 - Sixteen straps, fast-port and uplink enables/error latched in reset.
// RL6 - Serial modes take the debounce enable from strap bit 0.
// RL7 - Serial modes take the 3-bit device id from strap bits 6:4.
// RL8 - Unmanaged mode uses strap bit 7 for EEPROM loading.
// RL9 - Strap bit 9 enables module hot-swap on all ports.
// RL10 - Hot-swap module types come from fast-port and uplink strap levels.
// RL11 - With strap bit 11, idle port MACs enter reduced power.
// RL12 - Sleeping port MAC wakes as soon as activity returns.
// RL13 - Strap bit 12 arms a monitor flagging states busy over 5 seconds.
// RL14 - Strap bit 0 high enables debounce, low disables it.
// RL15 - Strap bit 7 high disables EEPROM load, low enables it.
// RL16 - Strap bit 9 high enables hot-swap, low disables it.
// RL17 - Strap bit 12 low disables timeout monitor, high enables it.
// RL18 - Latched straps stay constant from reset release until next reset.
// RL19 - 8-bit parallel mode uses only the lower eight data pins.
`default_nettype none
`include "sdmpm_defs.svh"
module sdmpm_strap_decode #(
  parameter int unsigned NPORT       = 3,
  parameter int unsigned TIMEOUT_CYC = `SDMPM_TIMEOUT_CYC,
  parameter int unsigned IDLE_CYC    = `SDMPM_IDLE_CYC
) (
  input  wire logic              clk_i,              // System clock
  input  wire logic              sys_rst_i,          // Sync reset, high
  input  wire logic              ce_i,               // Clock enable
  input  wire logic [15:0]       config_strap_bus_i, // Strap pins
  input  wire logic [1:0]        fast_port_tx_enable_i, // Fast tx enables
  input  wire logic              uplink_tx_enable_i, // Uplink tx enable
  input  wire logic              uplink_tx_error_i,  // Uplink tx error
  input  wire logic [NPORT-1:0]  port_active_i,      // Port activity
  input  wire logic              fsm_busy_i,         // Any FSM non-idle
  input  wire logic              fsm_restart_i,      // Busy FSM changed
  output logic [2:0]             mgmt_mode_o,        // Latched mode code
  output logic                   par_en_o,           // Parallel bus on
  output logic [15:0]            par_data_en_o,      // Data pins in use
  output logic                   par_addr2_en_o,     // Address 2 in use
  output logic                   serial_en_o,        // Serial pins on
  output logic                   cpu_mii_en_o,       // CPU MII pins on
  output logic                   i2c_en_o,           // A0/A1 are I2C
  output logic                   debounce_en_o,      // Serial debounce
  output logic [2:0]             serial_dev_id_o,    // Serial device id
  output logic                   eeprom_load_en_o,   // EEPROM load
  output logic                   hotswap_en_o,       // Module detect
  output logic [3:0]             module_type_o,      // {up er,up en,f1,f0}
  output logic                   pwrsave_en_o,       // Power saving
  output logic [NPORT-1:0]       port_sleep_o,       // Port MAC asleep
  output logic                   timeout_en_o,       // Timeout monitor on
  output logic                   timeout_flag_o      // FSM stuck
);

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [3:0]  msync1;
    logic [3:0]  msync2;
    logic [15:0] strap;
    logic [3:0]  mstrap;
    logic [31:0] tcnt;
    logic        tflag;
  } sdmpm_state_t;

  sdmpm_state_t s_q, s_d;

  function automatic sdmpm_pkg::sdmpm_if_t decode_mode(
    input logic [2:0] code
  );
    // RL1 mode decode
    case (code)
      `SDMPM_CODE_PAR16:     decode_mode = sdmpm_pkg::SDMPM_IF_PAR16;
      `SDMPM_CODE_PAR8:      decode_mode = sdmpm_pkg::SDMPM_IF_PAR8;
      `SDMPM_CODE_SER_MII:   decode_mode = sdmpm_pkg::SDMPM_IF_SER_MII;
      `SDMPM_CODE_SER_ONLY:  decode_mode = sdmpm_pkg::SDMPM_IF_SER;
      `SDMPM_CODE_UNMANAGED: decode_mode = sdmpm_pkg::SDMPM_IF_UNMAN;
      default:               decode_mode = sdmpm_pkg::SDMPM_IF_RSVD;
    endcase
  endfunction : decode_mode

  function automatic logic is_serial(input sdmpm_pkg::sdmpm_if_t m);
    is_serial = (m == sdmpm_pkg::SDMPM_IF_SER_MII) ||
                (m == sdmpm_pkg::SDMPM_IF_SER) ||
                (m == sdmpm_pkg::SDMPM_IF_UNMAN);
  endfunction : is_serial

  sdmpm_pkg::sdmpm_if_t mode;
  logic                 ser;

  always_comb
  begin
    s_d          = s_q;
    // Pins are asynchronous to clk, so two stages before use
    s_d.sync1    = config_strap_bus_i;
    s_d.sync2    = s_q.sync1;
    s_d.msync1   = {uplink_tx_error_i, uplink_tx_enable_i,
                    fast_port_tx_enable_i};
    s_d.msync2   = s_q.msync1;
    // RL5 capture while reset held
    // RL18 frozen after release
    if (sys_rst_i)
    begin
      s_d.strap  = s_q.sync2;
      s_d.mstrap = s_q.msync2;
    end
    // RL13 stuck-state monitor
    if (!timeout_en_o || !fsm_busy_i || fsm_restart_i)
      s_d.tcnt = 32'h0;
    else if (s_q.tcnt < TIMEOUT_CYC)
      s_d.tcnt = s_q.tcnt + 32'h1;
    s_d.tflag = timeout_en_o && fsm_busy_i && !fsm_restart_i &&
                (s_q.tcnt >= TIMEOUT_CYC);
  end

  // Straps keep sampling during reset; the last value seen before
  // release is the one the device runs with.
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      s_q.sync1  <= s_d.sync1;
      s_q.sync2  <= s_d.sync2;
      s_q.msync1 <= s_d.msync1;
      s_q.msync2 <= s_d.msync2;
      s_q.strap  <= s_d.strap;
      s_q.mstrap <= s_d.mstrap;
    end
    if (sys_rst_i)
    begin
      s_q.tcnt     <= 32'h0;
      s_q.tflag    <= 1'b0;
    end
    else if (ce_i)
    begin
      s_q.tcnt     <= s_d.tcnt;
      s_q.tflag    <= s_d.tflag;
    end
  end

  // ---------------------------------------------------------------
  // Decode and pin remap
  // ---------------------------------------------------------------
  assign mode        = decode_mode(s_q.strap[`SDMPM_MODE_MSB:`SDMPM_MODE_LSB]);
  assign ser         = is_serial(mode);
  assign mgmt_mode_o = s_q.strap[`SDMPM_MODE_MSB:`SDMPM_MODE_LSB];
  assign par_en_o    = (mode == sdmpm_pkg::SDMPM_IF_PAR16) ||
                       (mode == sdmpm_pkg::SDMPM_IF_PAR8);

  // RL2 RL19 data pin use
  assign par_data_en_o  = (mode == sdmpm_pkg::SDMPM_IF_PAR16) ? 16'hffff :
                          (mode == sdmpm_pkg::SDMPM_IF_PAR8)  ? 16'h00ff :
                          16'h0000;
  assign par_addr2_en_o = par_en_o;
  // RL4 serial pin reuse
  assign serial_en_o    = ser;
  assign cpu_mii_en_o   = (mode == sdmpm_pkg::SDMPM_IF_SER_MII);
  // RL3 I2C only on 111
  assign i2c_en_o       = (mode == sdmpm_pkg::SDMPM_IF_UNMAN);

  // RL6 RL14 debounce
  assign debounce_en_o    = ser && s_q.strap[`SDMPM_BIT_DEBOUNCE];
  // RL7 device id
  assign serial_dev_id_o  = ser ?
    s_q.strap[`SDMPM_DEVID_MSB:`SDMPM_DEVID_LSB] : 3'h0;
  // RL8 RL15 EEPROM load, low enables
  assign eeprom_load_en_o = (mode == sdmpm_pkg::SDMPM_IF_UNMAN) &&
                            !s_q.strap[`SDMPM_BIT_EEPROM_DIS];
  // RL9 RL16 hot-swap
  assign hotswap_en_o     = s_q.strap[`SDMPM_BIT_HOTSWAP];
  // RL10 module types
  assign module_type_o    = hotswap_en_o ? s_q.mstrap : 4'h0;
  assign pwrsave_en_o     = s_q.strap[`SDMPM_BIT_PWRSAVE];
  // RL17 timeout enable
  assign timeout_en_o     = s_q.strap[`SDMPM_BIT_TIMEOUT];
  assign timeout_flag_o   = s_q.tflag;

  // ---------------------------------------------------------------
  // Per-port power saving
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++)
    begin : g_port
      sdmpm_port_ps #(
        .IDLE_CYC (IDLE_CYC)
      ) u_ps (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .enable_i  (pwrsave_en_o),
        .active_i  (port_active_i[gi]),
        .sleep_o   (port_sleep_o[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(!sys_rst_i) |-> $stable(s_q.strap);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed"); // RL18

  property p_ser_only;
    @(posedge clk_i)
    (mgmt_mode_o == `SDMPM_CODE_SER_ONLY ||
     mgmt_mode_o == `SDMPM_CODE_UNMANAGED) |->
      (par_data_en_o == 16'h0000) && !par_addr2_en_o;
  endproperty
  a_ser_only: assert property (p_ser_only) else $error("pins used"); // RL2

  property p_i2c;
    @(posedge clk_i) i2c_en_o |-> (mgmt_mode_o == `SDMPM_CODE_UNMANAGED);
  endproperty
  a_i2c: assert property (p_i2c) else $error("i2c outside 111"); // RL3

  property p_par8;
    @(posedge clk_i) (mgmt_mode_o == `SDMPM_CODE_PAR8) |->
      par_data_en_o == 16'h00ff;
  endproperty
  a_par8: assert property (p_par8) else $error("par8 width"); // RL19

  property p_mii;
    @(posedge clk_i) cpu_mii_en_o |-> serial_en_o && !par_en_o;
  endproperty
  a_mii: assert property (p_mii) else $error("mii mode"); // RL1

  property p_dbn;
    @(posedge clk_i)
    debounce_en_o |-> serial_en_o && s_q.strap[`SDMPM_BIT_DEBOUNCE];
  endproperty
  a_dbn: assert property (p_dbn) else $error("debounce"); // RL14

  property p_eep;
    @(posedge clk_i)
    eeprom_load_en_o |-> !s_q.strap[`SDMPM_BIT_EEPROM_DIS] && i2c_en_o;
  endproperty
  a_eep: assert property (p_eep) else $error("eeprom"); // RL15

  property p_tout;
    @(posedge clk_i) disable iff (sys_rst_i)
    timeout_flag_o |-> $past(timeout_en_o) && $past(fsm_busy_i);
  endproperty
  a_tout: assert property (p_tout) else $error("timeout flag"); // RL13

endmodule : sdmpm_strap_decode
`default_nettype wire

// File: tb/sdmpm_strap_net.sv
// Strap resistor network and the shared-pin traffic that follows reset
`default_nettype none
module sdmpm_strap_net
(
  input  wire logic        clk_i,                 // System clock
  input  wire logic        sys_rst_i,             // Board reset
  input  wire logic [19:0] strap_i,               // {uer,uen,fast,straps}
  output logic      [15:0] config_strap_bus_o,    // Strap pins
  output logic      [1:0]  fast_port_tx_enable_o, // Fast tx enables
  output logic             uplink_tx_enable_o,    // Uplink tx enable
  output logic             uplink_tx_error_o      // Uplink tx error
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [19:0] pins_q;

  // Once reset ends the pins carry live traffic, so they never rest
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      pins_q <= strap_i;
    else
      pins_q <= ~pins_q;
  end

  assign {uplink_tx_error_o, uplink_tx_enable_o, fast_port_tx_enable_o,
          config_strap_bus_o} = pins_q;
endmodule : sdmpm_strap_net
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the strap decoder
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Shortened counts keep the run small
  // ------------------------------------------------------------
  localparam int unsigned TO_CYC = 20;
  localparam int unsigned IDLE   = 4;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [19:0] strap = '0;
  logic [2:0]  active = 3'h7;
  logic        busy = 1'b0;
  logic        ce = 1'b1;
  logic        restart = 1'b0;
  logic [15:0] sbus;
  logic [1:0]  fen;
  logic        uen, uer;
  logic [2:0]  mode, devid;
  logic [15:0] pden;
  logic [3:0]  mtype;
  logic [2:0]  sleep;
  logic        paren, pa2, seren, miien, i2cen, deb, eel;
  logic        hsw, psen, toen, toflag;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;

  always #12.5 clk_i = ~clk_i;

  sdmpm_strap_net i_net (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .strap_i(strap), .config_strap_bus_o(sbus),
    .fast_port_tx_enable_o(fen), .uplink_tx_enable_o(uen),
    .uplink_tx_error_o(uer));

  sdmpm_strap_decode #(.NPORT(3), .TIMEOUT_CYC(TO_CYC), .IDLE_CYC(IDLE))
  i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .config_strap_bus_i(sbus), .fast_port_tx_enable_i(fen),
    .uplink_tx_enable_i(uen), .uplink_tx_error_i(uer),
    .port_active_i(active), .fsm_busy_i(busy), .fsm_restart_i(restart),
    .mgmt_mode_o(mode), .par_en_o(paren), .par_data_en_o(pden),
    .par_addr2_en_o(pa2), .serial_en_o(seren), .cpu_mii_en_o(miien),
    .i2c_en_o(i2cen), .debounce_en_o(deb), .serial_dev_id_o(devid),
    .eeprom_load_en_o(eel), .hotswap_en_o(hsw), .module_type_o(mtype),
    .pwrsave_en_o(psen), .port_sleep_o(sleep), .timeout_en_o(toen),
    .timeout_flag_o(toflag));

  task automatic test_done();
  begin
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask : chk

  // Straps must stand still long enough to clear the synchronisers
  task automatic do_reset(input logic [19:0] s);
  begin
    @(posedge clk_i);
    strap <= s;
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
  end
  endtask : do_reset

  task automatic t_modes();
    logic [2:0]  c;
    logic [15:0] s;
    logic        ser;
  begin
    for (int i = 0; i < 16; i++)
    begin
      c = i[2:0];
      s = {8'h00, i[3], c ^ 3'h5, c, i[0] ^ i[3]};
      ser = (c == 3'h2) || (c == 3'h3) || (c == 3'h7);
      do_reset({4'h0, s});
      chk(mode, c);
      chk(paren, c < 3'h2);
      chk(miien, c == 3'h2);
      chk(pden, c == 0 ? 16'hffff : c == 1 ? 16'h00ff : 16'h0);
      chk(pa2, c < 3'h2);
      chk(i2cen, c == 3'h7);
      chk(seren, ser);
      chk(deb, ser & s[0]);
      chk(devid, ser ? s[6:4] : 3'h0);
      chk(eel, c == 3'h7 && !s[7]);
    end
  end
  endtask : t_modes

  task automatic t_feat();
    logic [19:0] s;
  begin
    for (int i = 0; i < 2; i++)
    begin
      s = i ? 20'h51a00 : 20'ha0000;
      do_reset(s);
      for (int k = 0; k < 2; k++)
      begin
        // Both passes run while the shared pins toggle, the second five cycles later
        chk(hsw, s[9]);
        chk(mtype, s[9] ? s[19:16] : 4'h0);
        chk(psen, s[11]);
        chk(toen, s[12]);
        repeat (5) @(negedge clk_i);
      end
    end
  end
  endtask : t_feat

  task automatic t_power();
    int n;
  begin
    @(posedge clk_i);
    active <= 3'h7;
    do_reset(20'h00800);
    @(posedge clk_i);
    active <= 3'h6;
    n = 0;
    while (sleep[0] !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= IDLE && n <= IDLE + 3, 1'b1);
    chk(sleep, 3'h1);
    // Low clock enable must hold the port asleep despite activity
    @(posedge clk_i);
    ce <= 1'b0;
    active <= 3'h7;
    repeat (3) @(negedge clk_i);
    chk(sleep, 3'h1);
    @(posedge clk_i);
    ce <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(sleep, 3'h0);
  end
  endtask : t_power

  task automatic t_timeout();
    int n;
  begin
    @(posedge clk_i);
    active <= 3'h0;
    do_reset(20'h01000);
    @(posedge clk_i);
    busy <= 1'b1;
    n = 0;
    while (toflag !== 1'b1 && n < TO_CYC + 10)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= TO_CYC && n <= TO_CYC + 3, 1'b1);
    chk(sleep, 3'h0);
    @(posedge clk_i);
    busy <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(toflag, 1'b0);
    // A restart mid-count pushes the flag out a full period
    @(posedge clk_i);
    busy <= 1'b1;
    repeat (10) @(posedge clk_i);
    restart <= 1'b1;
    @(posedge clk_i);
    restart <= 1'b0;
    n = 0;
    while (toflag !== 1'b1 && n < TO_CYC + 10)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= TO_CYC && n <= TO_CYC + 3, 1'b1);
    do_reset(20'h0);
    @(posedge clk_i);
    busy <= 1'b1;
    repeat (TO_CYC + 10) @(negedge clk_i);
    chk(toflag, 1'b0);
  end
  endtask : t_timeout

  // Runaway guard, far above the few hundred cycles needed
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    t_modes();
    t_feat();
    t_power();
    t_timeout();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
